// ===== bench/flash_array_model.sv
// array and query model behind the read path
// assumes contents follow the address, no storage
`timescale 1ns/10ps
module flash_array_model (
   input wire logic [25:0] addr_in,
   output logic [255:0] page_out,
   output logic [15:0] query_out
);
   always_comb begin
      for (int k = 0; k < 16; k++) page_out[16*k +: 16] = {addr_in[15:4], 4'(k)};
      query_out = ~addr_in[15:0];
   end
endmodule

// ===== bench/flash_cmd_asserts.sv
// checker on the command interface ports
// assumes one clock, async active high reset
`timescale 1ns/10ps
module flash_cmd_asserts #(parameter int OP_CYCLES = 40) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic pin_rst_n_in,
   input wire logic we_n_in,
   input wire logic op_valid_out,
   input flash_cmd_pkg::op_kind_t op_kind_out,
   input wire logic [25:0] op_addr_out,
   input wire logic wait_out,
   input wire logic ready_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // suspend or pin reset may end the busy time early, never late
   localparam int BUSY_MAX = OP_CYCLES + 20;
   sequence s_busy; !ready_out [*8]; endsequence
   sequence s_timed;
      op_valid_out && op_kind_out inside {flash_cmd_pkg::OP_WORD_PROG, flash_cmd_pkg::OP_ERASE,
         flash_cmd_pkg::OP_OTP_PROG, flash_cmd_pkg::OP_BLANK_CHECK, flash_cmd_pkg::OP_BUF_PROG,
         flash_cmd_pkg::OP_EXT_FUNC};
   endsequence
   property p_pulse; op_valid_out |=> !op_valid_out; endproperty
   property p_kind; !op_valid_out |-> $stable(op_kind_out); endproperty
   property p_addr; !op_valid_out |-> $stable(op_addr_out); endproperty
   property p_idle; s_timed |-> $past(ready_out); endproperty
   property p_time; s_timed |=> s_busy ##[1:BUSY_MAX] ready_out; endproperty
   property p_pinrst; (!pin_rst_n_in) [*7] |-> ready_out; endproperty
   property p_wait; (we_n_in && pin_rst_n_in) [*8] |-> $stable(wait_out); endproperty
   property p_rst; disable iff (1'b0) rst_in |-> ready_out && !op_valid_out; endproperty
   a_pulse: assert property (p_pulse) else $error("op pulse long");
   a_kind: assert property (p_kind) else $error("kind moved");
   a_addr: assert property (p_addr) else $error("addr moved");
   a_idle: assert property (p_idle) else $error("op while busy");
   a_time: assert property (p_time) else $error("op timing");
   a_pinrst: assert property (p_pinrst) else $error("pin reset kept busy");
   a_wait: assert property (p_wait) else $error("wait moved");
   a_rst: assert property (p_rst) else $error("reset values");
endmodule

// ===== bench/flash_command_read_interface_tb_top.sv
// self-checking bench for the flash command and read interface
// assumes the array model answers the read path
`timescale 1ns/10ps
module flash_command_read_interface_tb_top;
   localparam logic [15:0] MAKER = 16'h1234; // arbitrary value
   logic clk_in = 1'b0;
   logic rst_in = 1'b0;
   logic pin_rst_n = 1'b1, ce_n = 1'b1, we_n = 1'b1, oe_n = 1'b1, adv_n = 1'b0;
   logic [25:0] addr = 26'h0, arr_addr, op_addr, last_addr;
   logic [15:0] dq = 16'h0, query, dq_out, op_data, last_data;
   logic [255:0] page;
   logic dq_oe, wait_o, op_valid, ready;
   flash_cmd_pkg::op_kind_t op_kind, last_kind;
   int err_count = 0, n_compared = 0, n_ops = 0, cycles = 0;
   always #12.5 clk_in = ~clk_in;
   flash_command_read_interface #(.OP_CYCLES(40), .MAKER_CODE(MAKER)) uut (
      .clk_in(clk_in), .rst_in(rst_in), .pin_rst_n_in(pin_rst_n), .ce_n_in(ce_n),
      .we_n_in(we_n), .oe_n_in(oe_n), .address_valid_n_in(adv_n), .addr_in(addr), .dq_in(dq),
      .array_page_in(page), .query_word_in(query), .dq_out(dq_out), .dq_oe_out(dq_oe),
      .wait_out(wait_o), .array_addr_out(arr_addr), .op_valid_out(op_valid),
      .op_kind_out(op_kind), .op_addr_out(op_addr), .op_data_out(op_data), .ready_out(ready));
   flash_array_model model (.addr_in(arr_addr), .page_out(page), .query_out(query));
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles > 20000) begin
         err_count++;
         complete_run();
      end
      if (op_valid === 1'b1) begin
         n_ops++;
         last_kind = op_kind;
         last_addr = op_addr;
         last_data = op_data;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // pins are sampled, so every phase lasts several clocks
   task automatic wr(input logic [25:0] a, input logic [15:0] d);
      addr <= a;
      dq <= d;
      ce_n <= 1'b0;
      we_n <= 1'b0;
      repeat (4) @(posedge clk_in);
      ce_n <= 1'b1;
      we_n <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask
   task automatic rc(input logic [25:0] a, input logic [15:0] exp);
      addr <= a;
      ce_n <= 1'b0;
      oe_n <= 1'b0;
      repeat (12) @(posedge clk_in);
      chk(dq_out, exp);
      chk({15'h0, dq_oe}, 16'h0001);
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask
   task automatic op2(input logic [25:0] a, input logic [15:0] c1, input logic [15:0] c2,
                      input flash_cmd_pkg::op_kind_t k);
      wr(a, c1);
      wr(a, c2);
      chk({12'h0, last_kind}, {12'h0, k});
      chk(last_addr[15:0], a[15:0]);
   endtask
   initial begin
      rst_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      rc(26'h23, 16'h0023);
      rc(26'h12F, 16'h012F);
      wr(26'h0, 16'h0070);
      rc(26'h155, 16'h0080);
      wr(26'h0, 16'h0090);
      rc(26'h0, MAKER);
      rc(26'h5, 16'h8000);
      wr(26'h0, 16'h0098);
      rc(26'h31, 16'hFFCE);
      wr(26'h0, 16'h00FF);
      rc(26'h1A0, 16'h01A0);
      op2(26'h40, 16'h0040, 16'h1234, flash_cmd_pkg::OP_WORD_PROG);
      chk(last_data, 16'h1234);
      repeat (60) @(posedge clk_in);
      rc(26'h0, 16'h0080);
      wr(26'h80, 16'h0020);
      wr(26'h80, 16'h00FF);
      rc(26'h0, 16'h00B0);
      wr(26'h0, 16'h0050);
      rc(26'h0, 16'h0080);
      op2(26'h100, 16'h0020, 16'h00D0, flash_cmd_pkg::OP_ERASE);
      wr(26'h0, 16'h00B0);
      rc(26'h0, 16'h00C0);
      wr(26'h0, 16'h00D0);
      repeat (60) @(posedge clk_in);
      rc(26'h0, 16'h0080);
      n_ops = 0;
      wr(26'h200, 16'h00E8);
      rc(26'h200, 16'h0080);
      wr(26'h200, 16'h0001);
      op2(26'h200, 16'h0AAA, 16'h0555, flash_cmd_pkg::OP_BUF_LOAD);
      wr(26'h200, 16'h00D0);
      chk(16'(n_ops), 16'h0003);
      chk({12'h0, last_kind}, {12'h0, flash_cmd_pkg::OP_BUF_PROG});
      repeat (60) @(posedge clk_in);
      op2(26'h300, 16'h0060, 16'h0001, flash_cmd_pkg::OP_LOCK);
      op2(26'h300, 16'h0060, 16'h002F, flash_cmd_pkg::OP_LOCK_DOWN);
      op2(26'h300, 16'h0060, 16'h00D0, flash_cmd_pkg::OP_UNLOCK);
      op2(26'h400, 16'h00BC, 16'h00D0, flash_cmd_pkg::OP_BLANK_CHECK);
      repeat (60) @(posedge clk_in);
      op2(26'h600, 16'h00C0, 16'h5A5A, flash_cmd_pkg::OP_OTP_PROG);
      chk(last_data, 16'h5A5A);
      repeat (60) @(posedge clk_in);
      wr(26'h800, 16'h00EB);
      wr(26'h800, 16'h0007);
      op2(26'h800, 16'h0000, 16'h1357, flash_cmd_pkg::OP_BUF_LOAD);
      wr(26'h800, 16'h00D0);
      chk({12'h0, last_kind}, {12'h0, flash_cmd_pkg::OP_EXT_FUNC});
      chk(last_data, 16'h0007);
      repeat (60) @(posedge clk_in);
      n_ops = 0;
      wr(26'h700, 16'h0080);
      wr(26'h700, 16'h00D0);
      for (int i = 0; i < flash_cmd_pkg::BUF_WORDS; i++) wr(26'h700, 16'(i));
      chk(16'(n_ops), 16'(flash_cmd_pkg::BUF_WORDS));
      chk({15'h0, ready}, 16'h0000);
      repeat (60) @(posedge clk_in);
      wr(26'h8400, 16'h0060);
      wr(26'h8400, 16'h0003);
      chk({15'h0, wait_o}, 16'h0000);
      rc(26'h45, 16'h0045);
      // latch an address, then move the pins: reads must keep the latched word
      addr <= 26'h2B;
      repeat (8) @(posedge clk_in);
      adv_n <= 1'b1;
      repeat (4) @(posedge clk_in);
      rc(26'h3C, 16'h002B);
      adv_n <= 1'b0;
      op2(26'h500, 16'h0020, 16'h00D0, flash_cmd_pkg::OP_ERASE);
      pin_rst_n <= 1'b0;
      repeat (8) @(posedge clk_in);
      pin_rst_n <= 1'b1;
      repeat (8) @(posedge clk_in);
      chk({15'h0, ready}, 16'h0001);
      chk({15'h0, wait_o}, 16'h0001);
      rc(26'h77, 16'h0077);
      complete_run();
   end
endmodule
bind flash_command_read_interface flash_cmd_asserts #(.OP_CYCLES(OP_CYCLES)) chk_i (
   .clk_in(clk_in), .rst_in(rst_in), .pin_rst_n_in(pin_rst_n_in), .we_n_in(we_n_in),
   .op_valid_out(op_valid_out), .op_kind_out(op_kind_out), .op_addr_out(op_addr_out),
   .wait_out(wait_out), .ready_out(ready_out));

// ===== hdl/flash_cmd_pkg.sv
// constants, codes and types for the flash command and read interface
// assumes one 40 MHz clock; pins are synchronised inside the design
package flash_cmd_pkg;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_WORD_PROG = 8'h40;
   localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
   localparam logic [7:0] CMD_FACTORY_PROG = 8'h80;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_LOCK = 8'h01;
   localparam logic [7:0] CMD_LOCK_DOWN = 8'h2F;
   localparam logic [7:0] CMD_RCR_SET = 8'h03;
   localparam logic [7:0] CMD_OTP_PROG = 8'hC0;
   localparam logic [7:0] CMD_BLANK_CHECK = 8'hBC;
   localparam logic [7:0] CMD_EXT_FUNC = 8'hEB;
   localparam int BUF_WORDS = 512;
   localparam int PAGE_WORDS = 16;
   localparam int PAGE_BITS = 4;
   localparam int SR_READY = 7;
   localparam int SR_ERASE_SUSP = 6;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR = 4;
   localparam int SR_PROG_SUSP = 2;
   localparam int RCR_PAGE_BIT = 15;
   localparam int RCR_WAIT_POL_BIT = 10;
   localparam int RCR_ADDR_LSB = 0;
   localparam logic [15:0] RCR_RESET = 16'h8000;
   localparam logic [7:0] ID_OFS_MAKER = 8'h00;
   localparam logic [7:0] ID_OFS_DEVICE = 8'h01;
   localparam logic [7:0] ID_OFS_RCR = 8'h05;
   localparam int CLK_PERIOD_NS = 25;
   localparam int OP_TIME_NS = 10000;
   localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {RD_ARRAY, RD_ID, RD_STATUS, RD_QUERY} read_state_t;
   typedef enum logic [3:0] {
      OP_NONE, OP_WORD_PROG, OP_BUF_LOAD, OP_BUF_PROG, OP_ERASE, OP_LOCK, OP_UNLOCK,
      OP_LOCK_DOWN, OP_OTP_PROG, OP_BLANK_CHECK, OP_EXT_FUNC
   } op_kind_t;
   typedef enum logic [3:0] {
      CMD_IDLE, CMD_SECOND, CMD_BUF_COUNT, CMD_BUF_DATA, CMD_BUF_CONFIRM, CMD_FAST_CONFIRM,
      CMD_FAST_DATA, CMD_EXT_SUBOP, CMD_EXT_COUNT, CMD_EXT_DATA, CMD_EXT_CONFIRM
   } cmd_state_t;
endpackage

// ===== hdl/flash_command_read_interface.sv
// command interface and asynchronous read path of a parallel nor flash
// assumes an outside array answers array_page_in for array_addr_out combinationally
`timescale 1ns/10ps
module flash_command_read_interface #(
   parameter int AW = 26,
   parameter int DW = 16,
   parameter int OP_CYCLES = flash_cmd_pkg::OP_CYCLES,
   parameter logic [15:0] MAKER_CODE = 16'h00A5,  // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h005A  // arbitrary value
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic pin_rst_n_in,
   input wire logic ce_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   input wire logic address_valid_n_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [DW-1:0] dq_in,
   input wire logic [flash_cmd_pkg::PAGE_WORDS*DW-1:0] array_page_in,
   input wire logic [DW-1:0] query_word_in,
   output logic [DW-1:0] dq_out,
   output logic dq_oe_out,
   output logic wait_out,
   output logic [AW-1:0] array_addr_out,
   output logic op_valid_out,
   output flash_cmd_pkg::op_kind_t op_kind_out,
   output logic [AW-1:0] op_addr_out,
   output logic [DW-1:0] op_data_out,
   output logic ready_out
);
   localparam int SW = AW + DW + 5;
   localparam int CW = $clog2(flash_cmd_pkg::BUF_WORDS);
   localparam int TW = $clog2(OP_CYCLES + 1);

   // refuse sizes the page and config logic cannot serve
   if (AW < 17 || DW != 16 || OP_CYCLES < 1) begin
      $error("flash_command_read_interface: unsupported parameters");
   end

   // pin synchroniser: three stages, a change counts once stages two and three agree
   logic [SW-1:0] meta_ff, sync2_ff, sync3_ff, pin_ff;
   logic prst_n, pce_n, pwe_n, poe_n, padv_n;
   logic [AW-1:0] paddr;
   logic [DW-1:0] pdq;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_ff <= '1;
         sync2_ff <= '1;
         sync3_ff <= '1;
         pin_ff <= '1;
      end else begin
         meta_ff <= {pin_rst_n_in, ce_n_in, we_n_in, oe_n_in, address_valid_n_in, addr_in, dq_in};
         sync2_ff <= meta_ff;
         sync3_ff <= sync2_ff;
         pin_ff <= (sync3_ff & ~(sync2_ff ^ sync3_ff)) | (pin_ff & (sync2_ff ^ sync3_ff));
      end
   end
   assign {prst_n, pce_n, pwe_n, poe_n, padv_n, paddr, pdq} = pin_ff;

   logic dev_rst;
   assign dev_rst = ~prst_n;

   // write capture: last value seen while both strobes low
   logic wr_act, wr_act_ff, wr_end;
   logic [AW-1:0] cap_addr_ff;
   logic [DW-1:0] cap_data_ff;
   logic [7:0] code;
   assign wr_act = ~pce_n & ~pwe_n;
   assign wr_end = wr_act_ff & ~wr_act;
   assign code = cap_data_ff[7:0];

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_act_ff <= 1'b0;
         cap_addr_ff <= '0;
         cap_data_ff <= '0;
      end else begin
         wr_act_ff <= wr_act;
         if (wr_act) begin
            cap_addr_ff <= paddr;
            cap_data_ff <= pdq;
         end
      end
   end

   // command decode
   flash_cmd_pkg::cmd_state_t state_ff, nxt_state;
   flash_cmd_pkg::read_state_t read_ff, nxt_read;
   logic [7:0] setup_ff;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic [DW-1:0] sub_ff;
   logic busy_ff, susp_ff, erase_op_ff;
   logic [TW-1:0] timer_ff;
   logic start_op, seq_err, clr_sr, do_susp, do_resume, set_rcr, emit;
   flash_cmd_pkg::op_kind_t kind;
   logic [DW-1:0] emit_data;
   logic running;
   assign running = busy_ff & ~susp_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_read = read_ff;
      nxt_cnt = cnt_ff;
      start_op = 1'b0;
      seq_err = 1'b0;
      clr_sr = 1'b0;
      do_susp = 1'b0;
      do_resume = 1'b0;
      set_rcr = 1'b0;
      emit = 1'b0;
      kind = flash_cmd_pkg::OP_NONE;
      emit_data = cap_data_ff;
      if (wr_end) begin
         unique case (state_ff)
            flash_cmd_pkg::CMD_IDLE: begin
               if (code == flash_cmd_pkg::CMD_READ_ARRAY) begin
                  nxt_read = flash_cmd_pkg::RD_ARRAY;
               end else if (code == flash_cmd_pkg::CMD_READ_ID) begin
                  nxt_read = flash_cmd_pkg::RD_ID;
               end else if (code == flash_cmd_pkg::CMD_READ_QUERY) begin
                  nxt_read = flash_cmd_pkg::RD_QUERY;
               end else if (code == flash_cmd_pkg::CMD_READ_STATUS) begin
                  nxt_read = flash_cmd_pkg::RD_STATUS;
               end else if (code == flash_cmd_pkg::CMD_SUSPEND) begin
                  do_susp = running;
                  nxt_read = flash_cmd_pkg::RD_STATUS;
               end else if (busy_ff) begin
                  // a running part takes nothing here; a suspended part takes only resume and status clear
                  do_resume = susp_ff && code == flash_cmd_pkg::CMD_CONFIRM;
                  clr_sr = susp_ff && code == flash_cmd_pkg::CMD_CLEAR_STATUS;
               end else if (code == flash_cmd_pkg::CMD_CLEAR_STATUS) begin
                  clr_sr = 1'b1;
               end else if (code == flash_cmd_pkg::CMD_BUF_PROG) begin
                  nxt_state = flash_cmd_pkg::CMD_BUF_COUNT;
                  nxt_read = flash_cmd_pkg::RD_STATUS;
               end else if (code == flash_cmd_pkg::CMD_EXT_FUNC) begin
                  nxt_state = flash_cmd_pkg::CMD_EXT_SUBOP;
                  nxt_read = flash_cmd_pkg::RD_STATUS;
               end else if (code == flash_cmd_pkg::CMD_WORD_PROG ||
                            code == flash_cmd_pkg::CMD_FACTORY_PROG ||
                            code == flash_cmd_pkg::CMD_ERASE ||
                            code == flash_cmd_pkg::CMD_LOCK_SETUP ||
                            code == flash_cmd_pkg::CMD_OTP_PROG ||
                            code == flash_cmd_pkg::CMD_BLANK_CHECK) begin
                  nxt_state = flash_cmd_pkg::CMD_SECOND;
               end
            end
            flash_cmd_pkg::CMD_SECOND: begin
               nxt_state = flash_cmd_pkg::CMD_IDLE;
               nxt_read = flash_cmd_pkg::RD_STATUS;
               emit = 1'b1;
               unique case (setup_ff)
                  flash_cmd_pkg::CMD_WORD_PROG: begin
                     kind = flash_cmd_pkg::OP_WORD_PROG;
                     start_op = 1'b1;
                  end
                  flash_cmd_pkg::CMD_OTP_PROG: begin
                     kind = flash_cmd_pkg::OP_OTP_PROG;
                     start_op = 1'b1;
                  end
                  flash_cmd_pkg::CMD_ERASE: begin
                     kind = flash_cmd_pkg::OP_ERASE;
                     start_op = code == flash_cmd_pkg::CMD_CONFIRM;
                  end
                  flash_cmd_pkg::CMD_BLANK_CHECK: begin
                     kind = flash_cmd_pkg::OP_BLANK_CHECK;
                     start_op = code == flash_cmd_pkg::CMD_CONFIRM;
                  end
                  flash_cmd_pkg::CMD_FACTORY_PROG: begin
                     emit = 1'b0;
                     if (code == flash_cmd_pkg::CMD_CONFIRM) begin
                        nxt_state = flash_cmd_pkg::CMD_FAST_DATA;
                        nxt_cnt = CW'(flash_cmd_pkg::BUF_WORDS - 1);
                     end
                  end
                  default: begin
                     // lock setup shares its first code with the config register
                     if (code == flash_cmd_pkg::CMD_RCR_SET) begin
                        set_rcr = 1'b1;
                        emit = 1'b0;
                        nxt_read = flash_cmd_pkg::RD_ARRAY;
                     end else if (code == flash_cmd_pkg::CMD_LOCK) begin
                        kind = flash_cmd_pkg::OP_LOCK;
                     end else if (code == flash_cmd_pkg::CMD_CONFIRM) begin
                        kind = flash_cmd_pkg::OP_UNLOCK;
                     end else if (code == flash_cmd_pkg::CMD_LOCK_DOWN) begin
                        kind = flash_cmd_pkg::OP_LOCK_DOWN;
                     end else begin
                        emit = 1'b0;
                     end
                  end
               endcase
               if (emit == 1'b0 && set_rcr == 1'b0 &&
                   nxt_state == flash_cmd_pkg::CMD_IDLE) begin
                  seq_err = 1'b1;
               end
               if (start_op == 1'b0 && (setup_ff == flash_cmd_pkg::CMD_ERASE ||
                                        setup_ff == flash_cmd_pkg::CMD_BLANK_CHECK)) begin
                  seq_err = 1'b1;
                  emit = 1'b0;
               end
            end
            flash_cmd_pkg::CMD_BUF_COUNT, flash_cmd_pkg::CMD_EXT_COUNT: begin
               if (cap_data_ff >= DW'(flash_cmd_pkg::BUF_WORDS)) begin
                  seq_err = 1'b1;
                  nxt_state = flash_cmd_pkg::CMD_IDLE;
               end else begin
                  nxt_cnt = cap_data_ff[CW-1:0];
                  nxt_state = (state_ff == flash_cmd_pkg::CMD_BUF_COUNT) ?
                     flash_cmd_pkg::CMD_BUF_DATA : flash_cmd_pkg::CMD_EXT_DATA;
               end
            end
            flash_cmd_pkg::CMD_BUF_DATA, flash_cmd_pkg::CMD_EXT_DATA,
            flash_cmd_pkg::CMD_FAST_DATA: begin
               emit = 1'b1;
               kind = flash_cmd_pkg::OP_BUF_LOAD;
               nxt_cnt = cnt_ff - 1'b1;
               if (cnt_ff == '0) begin
                  unique case (state_ff)
                     flash_cmd_pkg::CMD_BUF_DATA: nxt_state = flash_cmd_pkg::CMD_BUF_CONFIRM;
                     flash_cmd_pkg::CMD_EXT_DATA: nxt_state = flash_cmd_pkg::CMD_EXT_CONFIRM;
                     default: begin
                        start_op = 1'b1;
                        nxt_state = flash_cmd_pkg::CMD_IDLE;
                     end
                  endcase
               end
            end
            flash_cmd_pkg::CMD_BUF_CONFIRM, flash_cmd_pkg::CMD_EXT_CONFIRM: begin
               nxt_state = flash_cmd_pkg::CMD_IDLE;
               if (code == flash_cmd_pkg::CMD_CONFIRM) begin
                  start_op = 1'b1;
                  emit = 1'b1;
                  kind = (state_ff == flash_cmd_pkg::CMD_BUF_CONFIRM) ?
                     flash_cmd_pkg::OP_BUF_PROG : flash_cmd_pkg::OP_EXT_FUNC;
                  if (state_ff == flash_cmd_pkg::CMD_EXT_CONFIRM) begin
                     emit_data = sub_ff;
                  end
               end else begin
                  seq_err = 1'b1;
               end
            end
            flash_cmd_pkg::CMD_EXT_SUBOP: begin
               nxt_state = flash_cmd_pkg::CMD_EXT_COUNT;
            end
            default: begin
               nxt_state = flash_cmd_pkg::CMD_IDLE;
            end
         endcase
         if (seq_err) begin
            nxt_read = flash_cmd_pkg::RD_STATUS;
         end
      end
   end

   // sequence state and read state
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= flash_cmd_pkg::CMD_IDLE;
         read_ff <= flash_cmd_pkg::RD_ARRAY;
         setup_ff <= '0;
         cnt_ff <= '0;
         sub_ff <= '0;
      end else if (dev_rst) begin
         state_ff <= flash_cmd_pkg::CMD_IDLE;
         read_ff <= flash_cmd_pkg::RD_ARRAY;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         read_ff <= nxt_read;
         cnt_ff <= nxt_cnt;
         if (wr_end && state_ff == flash_cmd_pkg::CMD_IDLE) begin
            setup_ff <= code;
         end
         if (wr_end && state_ff == flash_cmd_pkg::CMD_EXT_SUBOP) begin
            sub_ff <= cap_data_ff;
         end
      end
   end

   // internally timed operation with suspend; the engine only runs from a command
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_ff <= 1'b0;
         susp_ff <= 1'b0;
         erase_op_ff <= 1'b0;
         timer_ff <= '0;
      end else if (dev_rst) begin
         busy_ff <= 1'b0;
         susp_ff <= 1'b0;
         timer_ff <= '0;
      end else if (start_op) begin
         busy_ff <= 1'b1;
         susp_ff <= 1'b0;
         erase_op_ff <= kind == flash_cmd_pkg::OP_ERASE;
         timer_ff <= TW'(OP_CYCLES - 1);
      end else if (do_susp) begin
         susp_ff <= 1'b1;
      end else if (do_resume) begin
         susp_ff <= 1'b0;
      end else if (running) begin
         if (timer_ff == '0) begin
            busy_ff <= 1'b0;
         end else begin
            timer_ff <= timer_ff - 1'b1;
         end
      end
   end

   // status errors: a new error wins over a clear in the same cycle
   logic [1:0] err_ff;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         err_ff <= '0;
      end else if (dev_rst) begin
         err_ff <= '0;
      end else if (seq_err) begin
         err_ff <= 2'h3;
      end else if (clr_sr) begin
         err_ff <= '0;
      end
   end

   logic [DW-1:0] status;
   always_comb begin
      status = '0;
      status[flash_cmd_pkg::SR_READY] = ~busy_ff | susp_ff;
      status[flash_cmd_pkg::SR_ERASE_SUSP] = susp_ff & erase_op_ff;
      status[flash_cmd_pkg::SR_PROG_SUSP] = susp_ff & ~erase_op_ff;
      status[flash_cmd_pkg::SR_ERASE_ERR] = err_ff[1];
      status[flash_cmd_pkg::SR_PROG_ERR] = err_ff[0];
   end

   // read configuration: value comes from the address lines of the writes
   logic [15:0] rcr_ff;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rcr_ff <= flash_cmd_pkg::RCR_RESET;
      end else if (dev_rst) begin
         rcr_ff <= flash_cmd_pkg::RCR_RESET;
      end else if (set_rcr) begin
         rcr_ff <= cap_addr_ff[flash_cmd_pkg::RCR_ADDR_LSB +: 16];
      end
   end

   // operation strobe to the array engine
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         op_valid_out <= 1'b0;
         op_kind_out <= flash_cmd_pkg::OP_NONE;
         op_addr_out <= '0;
         op_data_out <= '0;
         ready_out <= 1'b1;
      end else begin
         op_valid_out <= emit & ~dev_rst;
         ready_out <= status[flash_cmd_pkg::SR_READY];
         if (emit) begin
            op_kind_out <= kind;
            op_addr_out <= cap_addr_ff;
            op_data_out <= emit_data;
         end
      end
   end

   // read path; the burst clock pin has no port, so it cannot disturb these reads
   logic [AW-1:0] rd_addr_ff;
   logic [flash_cmd_pkg::PAGE_WORDS*DW-1:0] page_ff;
   logic [AW-flash_cmd_pkg::PAGE_BITS-1:0] tag_ff;
   logic page_vld_ff, rd_act, page_load;
   logic [DW-1:0] rd_word;
   assign rd_act = ~pce_n & ~poe_n & pwe_n & prst_n;
   // without the page bit every read resenses, which costs latency but stays correct
   assign page_load = ~rcr_ff[flash_cmd_pkg::RCR_PAGE_BIT] | ~page_vld_ff |
      (tag_ff != array_addr_out[AW-1:flash_cmd_pkg::PAGE_BITS]);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_addr_ff <= '0;
         array_addr_out <= '0;
      end else begin
         if (~padv_n) begin
            rd_addr_ff <= paddr;  // high address-valid holds the latched address
         end
         array_addr_out <= rd_addr_ff;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         page_ff <= '0;
         tag_ff <= '0;
         page_vld_ff <= 1'b0;
      end else if (dev_rst || wr_end) begin
         page_vld_ff <= 1'b0;
      end else if (page_load) begin
         page_ff <= array_page_in;
         tag_ff <= array_addr_out[AW-1:flash_cmd_pkg::PAGE_BITS];
         page_vld_ff <= 1'b1;
      end
   end

   always_comb begin
      rd_word = '0;
      unique case (read_ff)
         flash_cmd_pkg::RD_ARRAY: begin
            rd_word = page_ff[rd_addr_ff[flash_cmd_pkg::PAGE_BITS-1:0]*DW +: DW];
         end
         flash_cmd_pkg::RD_STATUS: begin
            rd_word = status;
         end
         flash_cmd_pkg::RD_ID: begin
            if (rd_addr_ff[7:0] == flash_cmd_pkg::ID_OFS_MAKER) begin
               rd_word = MAKER_CODE;
            end else if (rd_addr_ff[7:0] == flash_cmd_pkg::ID_OFS_DEVICE) begin
               rd_word = DEVICE_CODE;
            end else if (rd_addr_ff[7:0] == flash_cmd_pkg::ID_OFS_RCR) begin
               rd_word = rcr_ff;
            end
         end
         flash_cmd_pkg::RD_QUERY: begin
            rd_word = query_word_in;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dq_out <= '0;
         dq_oe_out <= 1'b0;
         wait_out <= ~flash_cmd_pkg::RCR_RESET[flash_cmd_pkg::RCR_WAIT_POL_BIT];
      end else begin
         dq_out <= rd_word;
         dq_oe_out <= rd_act;
         wait_out <= ~rcr_ff[flash_cmd_pkg::RCR_WAIT_POL_BIT];
      end
   end
endmodule
